//--- logic/card_regs_pkg.sv
// Package with register map, field positions, reset values and counts of the card register slice.
package card_regs_pkg;
	localparam logic [5:0] ADDR_BLOCK_TOTAL = 6'h00;
	localparam logic [5:0] ADDR_BLOCKS_LEFT = 6'h04;
	localparam logic [5:0] ADDR_RX_LO = 6'h08;
	localparam logic [5:0] ADDR_RX_HI = 6'h0c;
	localparam logic [5:0] ADDR_TX_LO = 6'h10;
	localparam logic [5:0] ADDR_TX_HI = 6'h14;
	localparam logic [5:0] ADDR_CMD_LO = 6'h18;
	localparam logic [5:0] ADDR_CMD_HI = 6'h1c;
	localparam logic [5:0] ADDR_ARG_LO = 6'h20;
	localparam logic [5:0] ADDR_ARG_HI = 6'h24;
	localparam logic [5:0] ADDR_CONTROL = 6'h28;
	localparam logic [5:0] ADDR_STATUS = 6'h2c;
	localparam logic [15:0] BLOCK_TOTAL_RESET = 16'h0000;
	localparam logic [15:0] BLOCKS_LEFT_RESET = 16'h0fff;
	localparam logic [15:0] DATA_REG_RESET = 16'h0000;
	localparam logic [15:0] CMD_LO_RESET = 16'h0000;
	localparam logic [15:0] CMD_LO_WRITE_MASK = 16'hffbf;
	localparam int CMD_STATUS_CLEAR_BIT = 15;
	localparam int CMD_INIT_CLOCKS_BIT = 14;
	localparam int CMD_DATA_PRESENT_BIT = 13;
	localparam int CMD_STREAM_SELECT_BIT = 12;
	localparam int CMD_DIRECTION_BIT = 11;
	localparam int CMD_BUSY_EXPECTED_BIT = 8;
	localparam int CMD_PUSH_PULL_BIT = 7;
	localparam int CMD_RESERVED_BIT = 6;
	localparam int CMD_INDEX_MSB = 5;
	localparam logic [5:0] CMD_STOP_TRANSMISSION = 6'h0c;
	localparam int CTRL_TX_SWAP_BIT = 0;
	localparam int STAT_RECEIVE_READY_BIT = 0;
	localparam int STAT_TRANSMIT_READY_BIT = 1;
	localparam int STAT_CMD_BUSY_BIT = 2;
	localparam int STAT_TRANSFER_ACTIVE_BIT = 3;
	localparam logic [6:0] INIT_CLOCK_COUNT = 7'h50;
	localparam logic [5:0] FRAME_HEAD_BITS = 6'h28;
	localparam logic [5:0] FRAME_LAST_BIT = 6'h2f;
	localparam logic [6:0] CRC7_POLY = 7'h09;
	typedef enum {LINK_IDLE, LINK_INIT, LINK_SEND, LINK_DONE} link_state_t;
endpackage : card_regs_pkg

//--- logic/card_cmd_if.sv
// Interface carrying one command request from the register side to the card link side.
`timescale 1ns/1ps
interface card_cmd_if;
	logic start_toggle;
	logic done_toggle;
	logic init_clocks;
	logic [5:0] index;
	logic [31:0] argument;
	modport ctrl (output start_toggle, output init_clocks, output index, output argument,
		input done_toggle);
	modport link (input start_toggle, input init_clocks, input index, input argument,
		output done_toggle);
endinterface : card_cmd_if

//--- logic/toggle_sync.sv
// Toggle crossing that turns a level change from another clock into a one-cycle pulse.
`timescale 1ns/1ps
module toggle_sync
(
	// Destination clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Toggle from the other domain and pulse out
	input wire logic toggle_i,
	output logic pulse_o
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= toggle_i;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign pulse_o = sync_reg ^ last_reg;
endmodule : toggle_sync

//--- logic/card_cmd_shifter.sv
// Card link side: optional init clocks, then a 48-bit command frame on the command line.
`timescale 1ns/1ps
module card_cmd_shifter
	import card_regs_pkg::*;
(
	// Link clock and its synchronised reset
	input wire logic link_clk_i,
	input wire logic link_reset_i,
	// Request from the register side
	card_cmd_if.link req,
	// Command line
	output logic cmd_o,
	output logic cmd_oe_o
);
	link_state_t state_reg;
	logic start_meta_reg;
	logic start_sync_reg;
	logic start_last_reg;
	logic done_reg;
	logic [6:0] count_reg;
	logic [39:0] shift_reg;
	logic [6:0] crc_reg;
	logic crc_fb;

	// Index and argument are held stable by the register side until done returns.
	assign req.done_toggle = done_reg;
	assign crc_fb = crc_reg[6] ^ shift_reg[39];

	always_ff @(posedge link_clk_i)
	begin
		if (link_reset_i)
		begin
			start_meta_reg <= 1'b0;
			start_sync_reg <= 1'b0;
			start_last_reg <= 1'b0;
		end
		else
		begin
			start_meta_reg <= req.start_toggle;
			start_sync_reg <= start_meta_reg;
			start_last_reg <= start_sync_reg;
		end
	end

	always_ff @(posedge link_clk_i)
	begin
		if (link_reset_i)
		begin
			state_reg <= LINK_IDLE;
			count_reg <= 7'h00;
			shift_reg <= 40'h00_0000_0000;
			crc_reg <= 7'h00;
			cmd_o <= 1'b1;
			cmd_oe_o <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				LINK_IDLE:
				begin
					cmd_oe_o <= 1'b0;
					cmd_o <= 1'b1;
					count_reg <= 7'h00;
					crc_reg <= 7'h00;
					shift_reg <= {2'b01, req.index, req.argument};
					if (start_sync_reg != start_last_reg)
					begin
						state_reg <= req.init_clocks ? LINK_INIT : LINK_SEND;
					end
				end
				LINK_INIT:
				begin
					cmd_oe_o <= 1'b1;
					cmd_o <= 1'b1;
					count_reg <= count_reg + 7'h01;
					if (count_reg == INIT_CLOCK_COUNT - 7'h01)
					begin
						count_reg <= 7'h00;
						state_reg <= LINK_SEND;
					end
				end
				LINK_SEND:
				begin
					cmd_oe_o <= 1'b1;
					count_reg <= count_reg + 7'h01;
					if (count_reg < {1'b0, FRAME_HEAD_BITS})
					begin
						cmd_o <= shift_reg[39];
						shift_reg <= {shift_reg[38:0], 1'b0};
						crc_reg <= {crc_reg[5:0], 1'b0} ^ (crc_fb ? CRC7_POLY : 7'h00);
					end
					else if (count_reg < {1'b0, FRAME_LAST_BIT})
					begin
						cmd_o <= crc_reg[6];
						crc_reg <= {crc_reg[5:0], 1'b0};
					end
					else
					begin
						cmd_o <= 1'b1;
						state_reg <= LINK_DONE;
					end
				end
				LINK_DONE:
				begin
					cmd_oe_o <= 1'b0;
					done_reg <= ~done_reg;
					state_reg <= LINK_IDLE;
				end
				default:
				begin
					state_reg <= LINK_IDLE;
				end
			endcase
		end
	end
endmodule : card_cmd_shifter

//--- logic/card_block_regs.sv
// Block count, data and command registers of the card controller on an Avalon-MM slave.
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module card_block_regs
	import card_regs_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Avalon-MM register slave
	input wire logic [5:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	// Card link
	input wire logic link_clk_i,
	output logic cmd_o,
	output logic cmd_oe_o,
	// Rest of the controller
	input wire logic block_done_i,
	input wire logic rx_word_valid_i,
	input wire logic [31:0] rx_word_i,
	input wire logic tx_word_take_i,
	output logic [31:0] tx_word_o,
	output logic tx_word_valid_o,
	output logic transfer_active_o,
	output logic transfer_write_o,
	output logic stream_mode_o,
	output logic busy_expected_o,
	output logic push_pull_o
);
	logic [15:0] block_total_reg;
	logic [15:0] blocks_left_reg;
	logic [15:0] rx_lo_reg;
	logic [15:0] rx_hi_reg;
	logic [15:0] tx_lo_reg;
	logic [15:0] tx_hi_reg;
	logic [15:0] command_lo_reg;
	logic [15:0] command_hi_reg;
	logic [15:0] argument_lo_reg;
	logic [15:0] argument_hi_reg;
	logic [15:0] control_reg;
	logic receive_ready_reg;
	logic transmit_ready_reg;
	logic cmd_busy_reg;
	logic finite_reg;
	logic start_toggle_reg;
	logic init_hold_reg;
	logic [5:0] index_hold_reg;
	logic [31:0] arg_hold_reg;
	logic link_rst_meta_reg;
	logic link_reset;
	logic done_pulse;
	logic accept;
	logic wr;
	logic stall;
	logic launch;
	logic [15:0] cmd_lo_new;
	logic [31:0] read_value;
	card_cmd_if cmd_bus ();

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
		input logic [3:0] be);
		merge16 = {be[1] ? data[15:8] : old[15:8], be[0] ? data[7:0] : old[7:0]};
	endfunction : merge16

	// ****************************************
	// Bus handshake
	// ****************************************
	// A command write waits while the link is still busy, so the held frame never changes mid-send.
	assign stall = write_i && address_i == ADDR_CMD_LO && cmd_busy_reg;
	assign accept = (read_i || write_i) && !waitrequest_o;
	assign wr = write_i && accept;
	assign launch = wr && address_i == ADDR_CMD_LO;
	assign cmd_lo_new = merge16(command_lo_reg, writedata_i, byteenable_i) & CMD_LO_WRITE_MASK;

	always_comb
	begin
		read_value = 32'h0000_0000;
		if (address_i == ADDR_BLOCK_TOTAL)
			read_value[15:0] = block_total_reg;
		else if (address_i == ADDR_BLOCKS_LEFT)
			read_value[15:0] = blocks_left_reg;
		else if (address_i == ADDR_RX_LO)
			read_value[15:0] = rx_lo_reg;
		else if (address_i == ADDR_RX_HI)
			read_value[15:0] = rx_hi_reg;
		else if (address_i == ADDR_TX_LO)
			read_value[15:0] = tx_lo_reg;
		else if (address_i == ADDR_TX_HI)
			read_value[15:0] = tx_hi_reg;
		else if (address_i == ADDR_CMD_LO)
			read_value[15:0] = command_lo_reg;
		else if (address_i == ADDR_CMD_HI)
			read_value[15:0] = command_hi_reg;
		else if (address_i == ADDR_ARG_LO)
			read_value[15:0] = argument_lo_reg;
		else if (address_i == ADDR_ARG_HI)
			read_value[15:0] = argument_hi_reg;
		else if (address_i == ADDR_CONTROL)
			read_value[15:0] = control_reg;
		else if (address_i == ADDR_STATUS)
		begin
			read_value[STAT_RECEIVE_READY_BIT] = receive_ready_reg;
			read_value[STAT_TRANSMIT_READY_BIT] = transmit_ready_reg;
			read_value[STAT_CMD_BUSY_BIT] = cmd_busy_reg;
			read_value[STAT_TRANSFER_ACTIVE_BIT] = transfer_active_o;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			waitrequest_o <= 1'b1;
			readdata_o <= 32'h0000_0000;
		end
		else if (accept)
			waitrequest_o <= 1'b1;
		else if ((read_i || write_i) && !stall)
		begin
			waitrequest_o <= 1'b0;
			readdata_o <= read_value;
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	// command register kept
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			block_total_reg <= BLOCK_TOTAL_RESET;
			command_lo_reg <= CMD_LO_RESET;
			command_hi_reg <= DATA_REG_RESET;
			argument_lo_reg <= DATA_REG_RESET;
			argument_hi_reg <= DATA_REG_RESET;
			control_reg <= DATA_REG_RESET;
			tx_lo_reg <= DATA_REG_RESET;
			tx_hi_reg <= DATA_REG_RESET;
		end
		else if (wr)
		begin
			if (address_i == ADDR_BLOCK_TOTAL)
				block_total_reg <= merge16(block_total_reg, writedata_i, byteenable_i);
			else if (address_i == ADDR_CMD_LO)
				command_lo_reg <= cmd_lo_new;
			else if (address_i == ADDR_CMD_HI)
				command_hi_reg <= merge16(command_hi_reg, writedata_i, byteenable_i);
			else if (address_i == ADDR_ARG_LO)
				argument_lo_reg <= merge16(argument_lo_reg, writedata_i, byteenable_i);
			else if (address_i == ADDR_ARG_HI)
				argument_hi_reg <= merge16(argument_hi_reg, writedata_i, byteenable_i);
			else if (address_i == ADDR_CONTROL)
				control_reg <= merge16(control_reg, writedata_i, byteenable_i);
			else if (address_i == ADDR_TX_LO)
				tx_lo_reg <= merge16(tx_lo_reg, writedata_i, byteenable_i);
			else if (address_i == ADDR_TX_HI)
				tx_hi_reg <= merge16(tx_hi_reg, writedata_i, byteenable_i);
		end
	end

	// ****************************************
	// Data registers and ready flags
	// ****************************************
	// little-endian receive
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			rx_lo_reg <= DATA_REG_RESET;
			rx_hi_reg <= DATA_REG_RESET;
		end
		else if (rx_word_valid_i)
		begin
			rx_lo_reg <= rx_word_i[15:0];
			rx_hi_reg <= rx_word_i[31:16];
		end
		else if (wr && address_i == ADDR_RX_LO)
			rx_lo_reg <= merge16(rx_lo_reg, writedata_i, byteenable_i);
		else if (wr && address_i == ADDR_RX_HI)
			rx_hi_reg <= merge16(rx_hi_reg, writedata_i, byteenable_i);
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			receive_ready_reg <= 1'b0;
			transmit_ready_reg <= 1'b0;
		end
		else
		begin
			if (rx_word_valid_i)
				receive_ready_reg <= 1'b1;
			else if ((launch && cmd_lo_new[CMD_STATUS_CLEAR_BIT]) ||
				(read_i && accept && address_i == ADDR_RX_HI))
				receive_ready_reg <= 1'b0;
			if (tx_word_take_i)
				transmit_ready_reg <= 1'b1;
			else if ((launch && cmd_lo_new[CMD_STATUS_CLEAR_BIT]) ||
				(wr && address_i == ADDR_TX_HI))
				transmit_ready_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			tx_word_o <= 32'h0000_0000;
			tx_word_valid_o <= 1'b0;
		end
		else if (wr && address_i == ADDR_TX_HI)
		begin
			tx_word_valid_o <= 1'b1;
			if (control_reg[CTRL_TX_SWAP_BIT])
				tx_word_o <= {tx_lo_reg[7:0], tx_lo_reg[15:8],
					writedata_i[7:0], writedata_i[15:8]};
			else
				tx_word_o <= {merge16(tx_hi_reg, writedata_i, byteenable_i), tx_lo_reg};
		end
		else if (tx_word_take_i)
			tx_word_valid_o <= 1'b0;
	end

	// ****************************************
	// Transfer control
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			transfer_active_o <= 1'b0;
			transfer_write_o <= 1'b0;
			stream_mode_o <= 1'b0;
			busy_expected_o <= 1'b0;
			push_pull_o <= 1'b0;
			finite_reg <= 1'b0;
			blocks_left_reg <= BLOCKS_LEFT_RESET;
		end
		else if (launch)
		begin
			busy_expected_o <= cmd_lo_new[CMD_BUSY_EXPECTED_BIT];
			push_pull_o <= cmd_lo_new[CMD_PUSH_PULL_BIT];
			if (cmd_lo_new[CMD_DATA_PRESENT_BIT])
			begin
				transfer_active_o <= 1'b1;
				transfer_write_o <= cmd_lo_new[CMD_DIRECTION_BIT];
				stream_mode_o <= cmd_lo_new[CMD_STREAM_SELECT_BIT];
				finite_reg <= !cmd_lo_new[CMD_STREAM_SELECT_BIT] && block_total_reg != 16'h0000;
				blocks_left_reg <= block_total_reg;
			end
			else if (cmd_lo_new[CMD_INDEX_MSB:0] == CMD_STOP_TRANSMISSION)
				transfer_active_o <= 1'b0;
		end
		else if (transfer_active_o && block_done_i)
		begin
			blocks_left_reg <= blocks_left_reg - 16'h0001;
			if (finite_reg && blocks_left_reg == 16'h0001)
				transfer_active_o <= 1'b0;
		end
	end

	// ****************************************
	// Command launch and link crossing
	// ****************************************
	// argument sent with command
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			cmd_busy_reg <= 1'b0;
			start_toggle_reg <= 1'b0;
			init_hold_reg <= 1'b0;
			index_hold_reg <= 6'h00;
			arg_hold_reg <= 32'h0000_0000;
		end
		else if (launch)
		begin
			cmd_busy_reg <= 1'b1;
			start_toggle_reg <= ~start_toggle_reg;
			init_hold_reg <= cmd_lo_new[CMD_INIT_CLOCKS_BIT];
			index_hold_reg <= cmd_lo_new[CMD_INDEX_MSB:0];
			arg_hold_reg <= {argument_hi_reg, argument_lo_reg};
		end
		else if (done_pulse)
			cmd_busy_reg <= 1'b0;
	end

	assign cmd_bus.start_toggle = start_toggle_reg;
	assign cmd_bus.init_clocks = init_hold_reg;
	assign cmd_bus.index = index_hold_reg;
	assign cmd_bus.argument = arg_hold_reg;

	always_ff @(posedge link_clk_i)
	begin
		link_rst_meta_reg <= reset_i;
		link_reset <= link_rst_meta_reg;
	end

	card_cmd_shifter u_shifter (
		.link_clk_i(link_clk_i),
		.link_reset_i(link_reset),
		.req(cmd_bus.link),
		.cmd_o(cmd_o),
		.cmd_oe_o(cmd_oe_o)
	);

	toggle_sync u_done_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.toggle_i(cmd_bus.done_toggle),
		.pulse_o(done_pulse)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence s_data_launch;
		launch && cmd_lo_new[CMD_DATA_PRESENT_BIT];
	endsequence
	sequence s_started;
		cmd_busy_reg && $changed(start_toggle_reg);
	endsequence

	property p_left_reset;
		$fell(reset_i) |-> blocks_left_reg == BLOCKS_LEFT_RESET;
	endproperty
	a_left_reset: assert property (p_left_reset) else $error("counter reset value wrong");
	property p_load;
		s_data_launch |=> blocks_left_reg == $past(block_total_reg) && transfer_active_o;
	endproperty
	a_load: assert property (p_load) else $error("counter not loaded");
	property p_finite_stop;
		transfer_active_o && finite_reg && blocks_left_reg == 16'h0001 && block_done_i &&
			!launch |=> !transfer_active_o && blocks_left_reg == 16'h0000;
	endproperty
	a_finite_stop: assert property (p_finite_stop) else $error("block transfer did not end");
	property p_endless;
		transfer_active_o && !finite_reg && !launch |=> transfer_active_o;
	endproperty
	a_endless: assert property (p_endless) else $error("endless transfer ended early");
	property p_start;
		launch |=> s_started;
	endproperty
	a_start: assert property (p_start) else $error("command write did not start link");
	property p_arg;
		launch |=> arg_hold_reg == $past({argument_hi_reg, argument_lo_reg});
	endproperty
	a_arg: assert property (p_arg) else $error("argument not carried");
	property p_cmd_kept;
		!(wr && address_i == ADDR_CMD_LO) |=> $stable(command_lo_reg);
	endproperty
	a_cmd_kept: assert property (p_cmd_kept) else $error("command register changed");
	property p_reserved;
		command_lo_reg[CMD_RESERVED_BIT] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");
	property p_clear;
		launch && cmd_lo_new[CMD_STATUS_CLEAR_BIT] && !rx_word_valid_i && !tx_word_take_i
			|=> !receive_ready_reg && !transmit_ready_reg;
	endproperty
	a_clear: assert property (p_clear) else $error("ready flags not cleared");
	property p_rx;
		rx_word_valid_i |=> rx_lo_reg == $past(rx_word_i[15:0]) &&
			rx_hi_reg == $past(rx_word_i[31:16]) && receive_ready_reg;
	endproperty
	a_rx: assert property (p_rx) else $error("receive word misplaced");
	property p_dir;
		s_data_launch |=> transfer_write_o == $past(cmd_lo_new[CMD_DIRECTION_BIT]);
	endproperty
	a_dir: assert property (p_dir) else $error("direction not taken");
endmodule : card_block_regs

//--- tb/card_frame_model.sv
// Card-side model that watches the command line and collects init clocks and frames.
`timescale 1ns/1ps
module card_frame_model
(
	// Link clock and command line
	input wire logic link_clk_i,
	input wire logic cmd_i,
	input wire logic cmd_oe_i,
	// Last frame and counts
	output logic [47:0] frame_o = 48'h0000_0000_0000,
	output int frame_count_o = 0,
	output int init_count_o = 0
);
	logic [47:0] sh = 48'h0000_0000_0000;
	int ones = 0;
	int nbit = 0;
	always @(posedge link_clk_i)
	begin
		if (!cmd_oe_i)
		begin
			ones <= 0;
			nbit <= 0;
		end
		else if (nbit == 0 && cmd_i)
			ones <= ones + 1;
		else if (nbit == 47)
		begin
			frame_o <= {sh[46:0], cmd_i};
			init_count_o <= ones;
			frame_count_o <= frame_count_o + 1;
			nbit <= 0;
			ones <= 0;
		end
		else
		begin
			sh <= {sh[46:0], cmd_i};
			nbit <= nbit + 1;
		end
	end
endmodule : card_frame_model

//--- tb/test_card_block_count_data_cmd_regs.sv
// Self-checking bench for the block count, data and command register slice.
`timescale 1ns/1ps
module test_card_block_count_data_cmd_regs
	import card_regs_pkg::*;
;
	logic clk_i = 1'b0;
	logic link_clk = 1'b0;
	logic reset_i = 1'b1;
	logic [5:0] address = 6'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic [31:0] rv;
	logic wreq;
	logic block_done = 1'b0;
	logic rx_valid = 1'b0;
	logic [31:0] rx_word = 32'h0000_0000;
	logic tx_take = 1'b0;
	logic [31:0] tx_word;
	logic tx_valid, active, dir_w, stream, busy_exp, pp, cmd, cmd_oe;
	logic [47:0] fr;
	int n_frames, n_init, nf;
	int n_errors = 0;
	int check_count = 0;

	initial forever #25 clk_i = ~clk_i;
	initial
	begin
		#7;
		forever #7.5 link_clk = ~link_clk;
	end

	card_block_regs u_dut (.clk_i(clk_i), .reset_i(reset_i), .address_i(address),
		.read_i(read), .write_i(write), .writedata_i(wdata), .byteenable_i(4'hf),
		.readdata_o(rdata), .waitrequest_o(wreq), .link_clk_i(link_clk), .cmd_o(cmd),
		.cmd_oe_o(cmd_oe), .block_done_i(block_done), .rx_word_valid_i(rx_valid),
		.rx_word_i(rx_word), .tx_word_take_i(tx_take), .tx_word_o(tx_word),
		.tx_word_valid_o(tx_valid), .transfer_active_o(active), .transfer_write_o(dir_w),
		.stream_mode_o(stream), .busy_expected_o(busy_exp), .push_pull_o(pp));

	card_frame_model u_card (.link_clk_i(link_clk), .cmd_i(cmd), .cmd_oe_i(cmd_oe),
		.frame_o(fr), .frame_count_o(n_frames), .init_count_o(n_init));

	// ****************************************
	// Bus cycles and comparisons
	// ****************************************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk_i);
		address <= a;
		wdata <= {16'h0000, d};
		write <= 1'b1;
		do
			@(posedge clk_i);
		while (wreq !== 1'b0);
		write <= 1'b0;
	endtask : wr

	task automatic rc(input logic [5:0] a, input logic [31:0] e);
		@(posedge clk_i);
		address <= a;
		read <= 1'b1;
		do
			@(posedge clk_i);
		while (wreq !== 1'b0);
		rv = rdata;
		read <= 1'b0;
		chk(rv, e);
	endtask : rc

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask : idle

	// The argument is loaded first, since the command write takes it at once.
	task automatic cmdw(input logic [15:0] c);
		wr(ADDR_CMD_LO, c);
		nf = n_frames;
		idle(3);
	endtask : cmdw

	task automatic blk(input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			block_done <= 1'b1;
			@(posedge clk_i);
			block_done <= 1'b0;
		end
		idle(2);
	endtask : blk

	task automatic frame(input logic [5:0] idx, input logic [31:0] arg, input int ini);
		int t = 0;
		while (n_frames == nf && t < 400)
		begin
			@(posedge clk_i);
			t++;
		end
		chk(n_frames == nf, 1'b0);
		chk({fr[47:40], fr[0]}, {2'b01, idx, 1'b1});
		chk(fr[39:8], arg);
		chk(n_init, ini);
	endtask : frame

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		logic [5:0] al[6] = '{ADDR_BLOCK_TOTAL, ADDR_RX_LO, ADDR_RX_HI, ADDR_TX_LO,
			ADDR_TX_HI, 6'h30};
		foreach (al[i]) rc(al[i], 32'h0000_0000);
		rc(ADDR_BLOCKS_LEFT, {16'h0000, BLOCKS_LEFT_RESET});
		wr(ADDR_BLOCKS_LEFT, 16'h1234);
		rc(ADDR_BLOCKS_LEFT, {16'h0000, BLOCKS_LEFT_RESET});
	endtask : t_reset

	task automatic t_cmd;
		wr(ADDR_ARG_LO, 16'hbeef);
		wr(ADDR_ARG_HI, 16'hdead);
		cmdw(16'h4051);
		frame(6'h11, 32'hdead_beef, 80);
		rc(ADDR_CMD_LO, 32'h0000_4011);
		wr(ADDR_ARG_LO, 16'h0001);
		cmdw(16'h0005);
		wr(ADDR_CMD_HI, 16'h00a5);
		frame(6'h05, 32'hdead_0001, 0);
		rc(ADDR_CMD_HI, 32'h0000_00a5);
	endtask : t_cmd

	task automatic t_block;
		wr(ADDR_BLOCK_TOTAL, 16'h0003);
		rc(ADDR_BLOCK_TOTAL, 32'h0000_0003);
		cmdw(16'h2819);
		chk({active, dir_w}, 2'b11);
		rc(ADDR_BLOCKS_LEFT, 32'h0000_0003);
		blk(1);
		rc(ADDR_BLOCKS_LEFT, 32'h0000_0002);
		blk(1);
		chk(active, 1'b1);
		blk(1);
		chk(active, 1'b0);
		rc(ADDR_BLOCKS_LEFT, 32'h0000_0000);
	endtask : t_block

	task automatic t_stream;
		wr(ADDR_BLOCK_TOTAL, 16'h0000);
		cmdw(16'h2012);
		chk({active, dir_w}, 2'b10);
		blk(5);
		chk(active, 1'b1);
		cmdw({10'h000, CMD_STOP_TRANSMISSION});
		chk(active, 1'b0);
		wr(ADDR_BLOCK_TOTAL, 16'h0001);
		cmdw(16'h3192);
		chk({stream, busy_exp, pp}, 3'b111);
		blk(2);
		chk(active, 1'b1);
		cmdw({10'h000, CMD_STOP_TRANSMISSION});
		chk(active, 1'b0);
		frame(CMD_STOP_TRANSMISSION, 32'hdead_0001, 0);
	endtask : t_stream

	task automatic t_data;
		@(posedge clk_i);
		rx_word <= 32'h1234_5678;
		rx_valid <= 1'b1;
		tx_take <= 1'b1;
		@(posedge clk_i);
		rx_valid <= 1'b0;
		tx_take <= 1'b0;
		rc(ADDR_STATUS, 32'h0000_0003);
		rc(ADDR_RX_LO, 32'h0000_5678);
		rc(ADDR_RX_HI, 32'h0000_1234);
		cmdw(16'h8000);
		rc(ADDR_STATUS, 32'h0000_0004);
		frame(6'h00, 32'hdead_0001, 0);
		idle(3);
		rc(ADDR_STATUS, 32'h0000_0000);
		wr(ADDR_TX_LO, 16'h1122);
		wr(ADDR_TX_HI, 16'h3344);
		idle(2);
		chk({tx_valid, tx_word}, {1'b1, 32'h3344_1122});
		wr(ADDR_CONTROL, 16'h0001);
		wr(ADDR_TX_LO, 16'h1122);
		wr(ADDR_TX_HI, 16'h3344);
		idle(2);
		chk(tx_word, 32'h2211_4433);
		rc(ADDR_TX_LO, 32'h0000_1122);
	endtask : t_data

	task automatic final_report;
		if (n_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	initial
	begin
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		t_reset;
		t_cmd;
		t_block;
		t_stream;
		t_data;
		final_report;
	end

	// A hung handshake would otherwise stall the run forever.
	initial
	begin
		#3_000_000;
		n_errors++;
		final_report;
	end
endmodule : test_card_block_count_data_cmd_regs
